/* asm_pkg.sv */
`default_nettype none
// ==========================================================================
// constants for the channel slot mapper
package asm_pkg;

    // ======================================================================
    // register port
    localparam int          NUM_CH     = 4;                  // channels 4 to 7
    localparam logic [7:0]  PAGE_SCFG  = 8'h00;              // page of the slot registers
    localparam logic [7:0]  ADDR_CH4   = 8'h0E;              // chan4_slot_config
    localparam logic [7:0]  ADDR_CH5   = 8'h0F;              // chan5_slot_config
    localparam logic [7:0]  ADDR_CH6   = 8'h10;              // chan6_slot_config
    localparam logic [7:0]  ADDR_CH7   = 8'h11;              // chan7_slot_config
    localparam logic [7:0]  RD_UNMAPPED = 8'h00;             // answer to unknown address

    // ======================================================================
    // field layout of a slot register
    localparam int          RSVD_BIT   = 7;                  // reserved, reads zero
    localparam int          LINE_BIT   = 6;                  // output line select
    localparam int          CODE_W     = 6;                  // slot code bits 5..0
    localparam int          CFG_W      = 7;                  // stored bits 6..0

    // ======================================================================
    // reset values: slot code, primary line
    localparam logic [6:0]  RST_CH4    = 7'h03;
    localparam logic [6:0]  RST_CH5    = 7'h04;
    localparam logic [6:0]  RST_CH6    = 7'h05;
    localparam logic [6:0]  RST_CH7    = 7'h06;

    // ======================================================================
    // serial frame
    localparam int          WORD_BITS  = 32;                 // bits per slot
    localparam int          BIT_W      = 5;                  // bit counter width
    localparam int          SLOT_W     = 7;                  // slot counter, one spare bit
    localparam logic [6:0]  TDM_SLOTS  = 7'h40;              // 64 slots per TDM frame
    localparam logic [6:0]  HALF_SLOTS = 7'h20;              // 32 slots per half frame
    localparam logic [4:0]  LAST_BIT   = 5'h1F;              // last bit of a slot

endpackage : asm_pkg
`default_nettype wire

/* asm_slot_hit.sv */
`timescale 1ns/10ps
`default_nettype none
// ==========================================================================
// one channel: does the current slot belong to it, and on which line
module asm_slot_hit
    import asm_pkg::*;
(
    input  wire logic [CODE_W-1:0] slotCode,
    input  wire logic              lineSel,
    input  wire logic              tdmMode,
    input  wire logic [SLOT_W-1:0] curSlot,
    input  wire logic              curRight,
    input  wire logic              sampleBit,
    output logic                   bitPrimary,
    output logic                   bitSecondary
);

    logic hit;

    // tdm: slot equals code; i2s/lj: half from code msb, slot from low bits
    always_comb begin
        if (tdmMode) begin
            hit = (curSlot < TDM_SLOTS) && (curSlot[CODE_W-1:0] == slotCode);
        end else begin
            hit = (curSlot < HALF_SLOTS) && (curRight == slotCode[CODE_W-1])
                  && (curSlot[CODE_W-2:0] == slotCode[CODE_W-2:0]);
        end
    end

    // steer the bit onto the chosen line
    assign bitPrimary   = hit && !lineSel && sampleBit;
    assign bitSecondary = hit && lineSel && sampleBit;

endmodule : asm_slot_hit
`default_nettype wire

/* asm_channel_mapper.sv */
`timescale 1ns/10ps
`default_nettype none
// ==========================================================================
// slot configuration registers and serial slot placement for channels 4..7
module asm_channel_mapper
    import asm_pkg::*;
(
    input  wire logic                           mclk,
    input  wire logic                           rst,
    // register port
    input  wire logic                           regWrEn,
    input  wire logic                           regRdEn,
    input  wire logic [7:0]                     regPage,
    input  wire logic [7:0]                     regAddr,
    input  wire logic [7:0]                     regWrData,
    output logic      [7:0]                     regRdData_r,
    output logic                                regRdValid_r,
    // serial frame timing and samples
    input  wire logic                           bitEn,
    input  wire logic                           frameStart,
    input  wire logic                           halfStart,
    input  wire logic                           tdmMode,
    input  wire logic [NUM_CH-1:0][WORD_BITS-1:0] chanSample,
    output logic                                primarySerialOut_r,
    output logic                                secondaryOut_r,
    output logic                                secondaryOutEn_r
);

    // ======================================================================
    // register file
    localparam logic [NUM_CH-1:0][7:0]       CH_ADDR = {ADDR_CH7, ADDR_CH6, ADDR_CH5, ADDR_CH4};
    localparam logic [NUM_CH-1:0][CFG_W-1:0] CH_RST  = {RST_CH7, RST_CH6, RST_CH5, RST_CH4};

    logic [NUM_CH-1:0][CFG_W-1:0] cfg_r;
    logic [NUM_CH-1:0][CFG_W-1:0] cfg_nxt;
    logic [NUM_CH-1:0]            addrHit;
    logic [7:0]                   regRdData_nxt;
    logic                         regRdValid_nxt;

    // ======================================================================
    // serial position and samples
    logic [BIT_W-1:0]                bitCnt_r, bitCnt_nxt;
    logic [SLOT_W-1:0]               slotCnt_r, slotCnt_nxt;
    logic                            right_r, right_nxt;
    logic [NUM_CH-1:0][WORD_BITS-1:0] held_r, held_nxt;
    logic [NUM_CH-1:0][WORD_BITS-1:0] useSample;
    logic [NUM_CH-1:0]               chanBit, bitPri, bitSec;
    logic                            primary_nxt, secondary_nxt, secondaryEn_nxt;

    // ======================================================================
    // per-channel decode, storage and slot match
    genvar ch;
    generate
        for (ch = 0; ch < NUM_CH; ch++) begin : g_chan
            assign addrHit[ch] = (regPage == PAGE_SCFG) && (regAddr == CH_ADDR[ch]);
            // bit 7 is dropped on write, bits 6..0 stored
            assign cfg_nxt[ch] = (regWrEn && addrHit[ch]) ? regWrData[CFG_W-1:0] : cfg_r[ch];
            assign useSample[ch] = frameStart ? chanSample[ch] : held_r[ch];
            assign chanBit[ch] = useSample[ch][LAST_BIT - bitCnt_nxt]; // msb first
            asm_slot_hit u_hit (
                .slotCode     (cfg_r[ch][CODE_W-1:0]),
                .lineSel      (cfg_r[ch][LINE_BIT]),
                .tdmMode      (tdmMode),
                .curSlot      (slotCnt_nxt),
                .curRight     (right_nxt),
                .sampleBit    (chanBit[ch]),
                .bitPrimary   (bitPri[ch]),
                .bitSecondary (bitSec[ch])
            );
        end
    endgenerate

    // read answer, one cycle after the strobe
    always_comb begin
        regRdData_nxt  = regRdData_r;
        regRdValid_nxt = regRdEn;
        if (regRdEn) begin
            regRdData_nxt = RD_UNMAPPED;
            for (int i = 0; i < NUM_CH; i++) begin
                if (addrHit[i]) begin
                    regRdData_nxt = {1'b0, cfg_r[i]};
                end
            end
        end
    end

    // register storage
    always_ff @(posedge mclk) begin
        if (rst) begin
            cfg_r        <= CH_RST;
            regRdData_r  <= 8'h00;
            regRdValid_r <= 1'b0;
        end else begin
            cfg_r        <= cfg_nxt;
            regRdData_r  <= regRdData_nxt;
            regRdValid_r <= regRdValid_nxt;
        end
    end

    // ======================================================================
    // frame position: frameStart / halfStart mark bit 0 of slot 0
    always_comb begin
        bitCnt_nxt  = bitCnt_r;
        slotCnt_nxt = slotCnt_r;
        right_nxt   = right_r;
        held_nxt    = held_r;
        if (bitEn) begin
            if (frameStart) begin
                bitCnt_nxt  = 5'h00;
                slotCnt_nxt = 7'h00;
                right_nxt   = 1'b0;
                held_nxt    = chanSample;
            end else if (halfStart && !tdmMode) begin
                bitCnt_nxt  = 5'h00;
                slotCnt_nxt = 7'h00;
                right_nxt   = 1'b1;
            end else begin
                bitCnt_nxt = bitCnt_r + 5'h01;
                if (bitCnt_r == LAST_BIT && slotCnt_r < TDM_SLOTS) begin
                    slotCnt_nxt = slotCnt_r + 7'h01; // stops past the last slot
                end
            end
        end
    end

    // line bits: channels on the same slot and line are or-ed
    always_comb begin
        primary_nxt     = primarySerialOut_r;
        secondary_nxt   = secondaryOut_r;
        secondaryEn_nxt = 1'b0;
        for (int i = 0; i < NUM_CH; i++) begin
            secondaryEn_nxt = secondaryEn_nxt | cfg_r[i][LINE_BIT];
        end
        if (bitEn) begin
            primary_nxt   = |bitPri;
            secondary_nxt = |bitSec;
        end
    end

    // serial state
    always_ff @(posedge mclk) begin
        if (rst) begin
            bitCnt_r           <= 5'h00;
            slotCnt_r          <= TDM_SLOTS; // idle until the first frame
            right_r            <= 1'b0;
            held_r             <= '0;
            primarySerialOut_r <= 1'b0;
            secondaryOut_r     <= 1'b0;
            secondaryOutEn_r   <= 1'b0;
        end else begin
            bitCnt_r           <= bitCnt_nxt;
            slotCnt_r          <= slotCnt_nxt;
            right_r            <= right_nxt;
            held_r             <= held_nxt;
            primarySerialOut_r <= primary_nxt;
            secondaryOut_r     <= secondary_nxt;
            secondaryOutEn_r   <= secondaryEn_nxt;
        end
    end

    // ======================================================================
    // checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    a_ch4_reset_value: assert property ($past(rst) |-> cfg_r[0] == RST_CH4)
        else $error("channel 4 register not at reset value");
    a_ch5_reset_value: assert property ($past(rst) |-> cfg_r[1] == RST_CH5)
        else $error("channel 5 register not at reset value");
    a_ch6_reset_value: assert property ($past(rst) |-> cfg_r[2] == RST_CH6)
        else $error("channel 6 register not at reset value");
    a_ch7_reset_value: assert property ($past(rst) |-> cfg_r[3] == RST_CH7)
        else $error("channel 7 register not at reset value");
    a_ch7_write_read: assert property (regWrEn && regPage == PAGE_SCFG && regAddr == ADDR_CH7
        ##1 regRdEn && !regWrEn && regPage == PAGE_SCFG && regAddr == ADDR_CH7
        |=> regRdValid_r && regRdData_r == {1'b0, $past(regWrData[6:0], 2)})
        else $error("channel 7 readback wrong");
    a_reserved_zero: assert property (regRdValid_r |-> !regRdData_r[RSVD_BIT])
        else $error("reserved bit read as one");
    // a secondary channel may legally share the slot, so only judge the idle secondary case
    a_primary_line: assert property (bitEn && tdmMode && !cfg_r[0][LINE_BIT]
        && slotCnt_nxt == {1'b0, cfg_r[0][5:0]} && chanBit[0] && bitSec == 4'h0
        |=> primarySerialOut_r && !secondaryOut_r)
        else $error("primary line missed channel bit");
    a_line_enable: assert property (secondaryOutEn_r == $past(cfg_r[0][LINE_BIT]
        | cfg_r[1][LINE_BIT] | cfg_r[2][LINE_BIT] | cfg_r[3][LINE_BIT]))
        else $error("secondary enable does not follow line selects");
    a_secondary_line: assert property (bitEn && tdmMode && cfg_r[1][LINE_BIT]
        && slotCnt_nxt == {1'b0, cfg_r[1][5:0]} && chanBit[1]
        |=> secondaryOut_r && secondaryOutEn_r)
        else $error("secondary line missed channel bit");
    a_left_half_slot: assert property (bitEn && !tdmMode && !right_nxt && !cfg_r[2][5]
        && !cfg_r[2][LINE_BIT] && slotCnt_nxt == {2'b00, cfg_r[2][4:0]} && chanBit[2]
        |=> primarySerialOut_r)
        else $error("left half slot not placed");
    a_right_half_slot: assert property (bitEn && !tdmMode && right_nxt && cfg_r[3][5]
        && !cfg_r[3][LINE_BIT] && slotCnt_nxt == {2'b00, cfg_r[3][4:0]} && chanBit[3]
        |=> primarySerialOut_r)
        else $error("right half slot not placed");
    a_idle_low: assert property (bitEn && bitPri == 4'h0 |=> !primarySerialOut_r)
        else $error("primary line driven with no channel in slot");

    c_tdm_frame: cover property (bitEn && frameStart && tdmMode ##[1:200] primarySerialOut_r);
    c_right_half: cover property (bitEn && halfStart && !tdmMode ##1 slotCnt_r == 7'h00);
    c_secondary_used: cover property (secondaryOutEn_r && secondaryOut_r);
    c_register_write: cover property (regWrEn && addrHit != 4'h0);

endmodule : asm_channel_mapper
`default_nettype wire

/* asm_dummy_unused.sv */
`default_nettype none
`default_nettype wire

/* asm_rx_model.sv */
`timescale 1ns/10ps
`default_nettype none
// ==========================================================================
// far-end receiver: frame timing out, both data lines captured per slot
module asm_rx_model
    import asm_pkg::*;
(
    input  wire logic mclk,
    input  wire logic run,
    input  wire logic tdmMode,
    input  wire logic primaryIn,
    input  wire logic secondaryIn,
    output logic      bitEn,
    output logic      frameStart,
    output logic      halfStart
);
    int          bitNo;
    int          issued;
    logic        pend;
    logic [31:0] priWord [64];
    logic [31:0] secWord [64];

    // one bit every second cycle; 2048 bits a frame, half marker at bit 1024
    always @(negedge mclk) begin
        bitEn      <= run && !bitEn;
        frameStart <= run && !bitEn && bitNo == 0;
        halfStart  <= run && !bitEn && bitNo == 1024 && !tdmMode;
        if (!run) begin
            bitNo <= 0;
        end else if (!bitEn) begin
            issued <= bitNo;
            bitNo  <= (bitNo + 1) % 2048;
        end
    end

    // a line bit stands the cycle after its enable, so it is taken there
    always @(posedge mclk) begin
        pend <= bitEn;
        if (pend) begin
            priWord[issued / 32][31 - issued % 32] <= primaryIn;
            secWord[issued / 32][31 - issued % 32] <= secondaryIn;
        end
    end
endmodule : asm_rx_model
`default_nettype wire

/* testbench.sv */
`timescale 1ns/10ps
`default_nettype none
// ==========================================================================
// self-checking bench for the channel slot mapper
module testbench
    import asm_pkg::*;
;
    logic                             mclk, rst, regWrEn, regRdEn, tdmMode, run;
    logic [7:0]                       regPage, regAddr, regWrData, regRdData_r;
    logic                             regRdValid_r, bitEn, frameStart, halfStart;
    logic                             primarySerialOut_r, secondaryOut_r, secondaryOutEn_r;
    logic [NUM_CH-1:0][WORD_BITS-1:0] chanSample;
    logic [6:0]                       cfg [NUM_CH];
    logic [6:0]                       dflt [NUM_CH];
    int                               n_errors = 0, num_checks = 0, cycles = 0;

    asm_channel_mapper dut_u (.mclk(mclk), .rst(rst), .regWrEn(regWrEn), .regRdEn(regRdEn),
        .regPage(regPage), .regAddr(regAddr), .regWrData(regWrData),
        .regRdData_r(regRdData_r), .regRdValid_r(regRdValid_r), .bitEn(bitEn),
        .frameStart(frameStart), .halfStart(halfStart), .tdmMode(tdmMode),
        .chanSample(chanSample), .primarySerialOut_r(primarySerialOut_r),
        .secondaryOut_r(secondaryOut_r), .secondaryOutEn_r(secondaryOutEn_r));
    asm_rx_model model_u (.mclk(mclk), .run(run), .tdmMode(tdmMode),
        .primaryIn(primarySerialOut_r), .secondaryIn(secondaryOut_r), .bitEn(bitEn),
        .frameStart(frameStart), .halfStart(halfStart));

    // ======================================================================
    // clock and hang guard
    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_errors++;
            wrap_up();
        end
    end

    // ======================================================================
    // shared tasks
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        num_checks++;
        if (seen !== want) begin
            n_errors++;
            $display("wrong value at %0t ns: got %h want %h", $time, seen, want);
        end
    endtask : check

    // one access per edge; strobes stay up until the next access or a frame lowers them
    task automatic regAccess(input logic wr, input logic [7:0] page, addr, data);
        regWrEn   = wr;
        regRdEn   = !wr;
        regPage   = page;
        regAddr   = addr;
        regWrData = data;
        @(negedge mclk);
    endtask : regAccess

    task automatic readCheck(input logic [7:0] page, addr, want);
        regAccess(1'b0, page, addr, 8'h00);
        check({regRdValid_r, regRdData_r}, {1'b1, want});
    endtask : readCheck

    function automatic logic [31:0] expWord(input int slot, input logic line);
        expWord = '0;
        for (int i = 0; i < NUM_CH; i++) begin
            if (cfg[i][LINE_BIT] == line && cfg[i][5:0] == slot) begin
                expWord |= chanSample[i];
            end
        end
    endfunction : expWord

    // ======================================================================
    // scenarios
    task automatic resetValues();
        check({primarySerialOut_r, secondaryOut_r, secondaryOutEn_r}, 3'h0);
        for (int i = 0; i < NUM_CH; i++) begin
            readCheck(PAGE_SCFG, ADDR_CH4 + 8'(i), {1'b0, dflt[i]});
        end
        readCheck(PAGE_SCFG, 8'h12, RD_UNMAPPED);
        readCheck(8'h01, ADDR_CH4, RD_UNMAPPED);
    endtask : resetValues

    // back-to-back writes with bit7 set, stray writes, then readback
    task automatic setCfg(input logic [6:0] a, b, c, d);
        cfg = '{a, b, c, d};
        for (int i = 0; i < NUM_CH; i++) begin
            regAccess(1'b1, PAGE_SCFG, ADDR_CH4 + 8'(i), {1'b1, cfg[i]});
        end
        readCheck(PAGE_SCFG, ADDR_CH7, {1'b0, cfg[3]});
        regAccess(1'b1, 8'h01, ADDR_CH4, 8'h00);
        regAccess(1'b1, PAGE_SCFG, 8'h12, 8'h00);
        for (int i = 0; i < NUM_CH; i++) begin
            readCheck(PAGE_SCFG, ADDR_CH4 + 8'(i), {1'b0, cfg[i]});
        end
    endtask : setCfg

    // one whole frame, then every slot of both lines compared
    task automatic runFrame(input logic tdm, input logic [WORD_BITS-1:0] base);
        tdmMode    = tdm;
        chanSample = {base ^ 32'h5A5A_C3C3, ~base, base + 32'h0101_0101, base};
        regWrEn    = 1'b0;
        regRdEn    = 1'b0;
        @(negedge mclk);
        check({regRdValid_r, regRdData_r}, {1'b0, 1'b0, cfg[3]});
        run <= 1'b1;
        repeat (4096) @(negedge mclk);
        run <= 1'b0;
        repeat (4) @(negedge mclk);
        for (int s = 0; s < 64; s++) begin
            check(model_u.priWord[s], expWord(s, 1'b0));
            check(model_u.secWord[s], expWord(s, 1'b1));
        end
        check(secondaryOutEn_r, cfg[0][6] | cfg[1][6] | cfg[2][6] | cfg[3][6]);
    endtask : runFrame

    task automatic wrap_up();
        if (n_errors == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : wrap_up

    // ======================================================================
    // main sequence
    initial begin
        dflt       = '{RST_CH4, RST_CH5, RST_CH6, RST_CH7};
        rst        = 1'b1;
        run        = 1'b0;
        regWrEn    = 1'b0;
        regRdEn    = 1'b0;
        regPage    = 8'h00;
        regAddr    = 8'h00;
        regWrData  = 8'h00;
        tdmMode    = 1'b1;
        chanSample = '0;
        repeat (4) @(negedge mclk);
        rst = 1'b0;
        resetValues();
        setCfg(7'h00, 7'h5F, 7'h20, 7'h7F);
        runFrame(1'b1, 32'h8421_C3A5);
        setCfg(7'h3F, 7'h40, 7'h60, 7'h60);
        runFrame(1'b0, 32'h9B1E_0F72);
        setCfg(7'h1F, 7'h21, 7'h00, 7'h3E);
        runFrame(1'b0, 32'hC001_7E3D);
        wrap_up();
    end
endmodule : testbench
`default_nettype wire
